// ===== bench/frpi_flash_model.sv
`timescale 1ns/1ns
module frpi_flash_model
#(
    parameter int OP_CYC = 6
)
(
    input  wire logic start_op,
    input  wire logic viol_req,
    input  wire logic aclk,
    output logic      flash_ready,
    output logic      prot_violation
);
    // busy for OP_CYC cycles per operation, violation held three cycles
    int busy_cnt = 0;
    int viol_cnt = 0;
    assign flash_ready    = (busy_cnt == 0);
    assign prot_violation = (viol_cnt != 0);
    always @(posedge aclk)
    begin
        if (start_op)
            busy_cnt <= OP_CYC;
        else if (busy_cnt != 0)
            busy_cnt <= busy_cnt - 1;
        if (viol_req)
            viol_cnt <= 3;
        else if (viol_cnt != 0)
            viol_cnt <= viol_cnt - 1;
    end
endmodule : frpi_flash_model

// ===== bench/frpi_monitor.sv
`timescale 1ns/1ns
module frpi_monitor
    import frpi_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              flash_ready,
    input wire logic              irq_n,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready
);
    // ****************************************
    // snooped control copy and write quiet time
    // ****************************************
    logic [4:0] ctl_r;
    logic [3:0] quiet_r;
    logic       wr_hs;
    assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctl_r   <= 5'h00;
            quiet_r <= 4'h0;
        end
        else
        begin
            if (wr_hs && s_axi_awaddr == BADDR_INT_CTRL && s_axi_wstrb[0])
                ctl_r <= s_axi_wdata[4:0];
            quiet_r <= wr_hs ? 4'h0 : (quiet_r == 4'hf ? quiet_r : quiet_r + 4'h1);
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************************************
    // assertions
    // ****************************************
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid not held");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid not held");
    a_write_answer: assert property (wr_hs |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    a_trig_off: assert property (ctl_r[3:0] == 4'h0 && quiet_r > 4'h3 |-> irq_n)
        else $error("irq asserted with triggers off");
    a_ready_irq: assert property (ctl_r[2:0] == 3'h1 && !ctl_r[4] && quiet_r > 4'h3
        && irq_n && $rose(flash_ready) |-> ##[2:4] !irq_n) else $error("no ready irq");
    a_level_hold: assert property (!ctl_r[4] && quiet_r > 4'h3 && !irq_n |=> !irq_n)
        else $error("level irq released without clear");
    a_pulse_width: assert property (ctl_r[4] && quiet_r > 4'h3 && $fell(irq_n)
        |-> !irq_n[*4] ##1 irq_n) else $error("irq pulse width wrong");
    c_level: cover property (!irq_n && !ctl_r[4]);
    c_pulse: cover property ($fell(irq_n) && ctl_r[4]);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : frpi_monitor

bind frpi_top frpi_monitor u_mon (.*);

// ===== bench/test_flash_ready_protect_irq.sv
`timescale 1ns/1ns
module test_flash_ready_protect_irq;
    import frpi_pkg::*;
    logic aclk = 0, aresetn = 0, ce = 1, start_op = 0, viol_req = 0;
    logic flash_ready, prot_violation, irq_n, evt_irq;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = '0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] d;
    int n_fail = 0;
    int cmp_count = 0;
    always #25 aclk = ~aclk;
    frpi_top dut (.*);
    frpi_flash_model flash (.*);
    // ****************************************
    // bus and compare tasks
    // ****************************************
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
        logic ap, wp;
        ap = 1;
        wp = 1;
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf; s_axi_wvalid <= 1; s_axi_bready <= 1;
        while (ap || wp)
        begin
            @(posedge aclk);
            if (ap && s_axi_awready) begin ap = 0; s_axi_awvalid <= 0; end
            if (wp && s_axi_wready) begin wp = 0; s_axi_wvalid <= 0; end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 0;
        chk("bresp", 32'(RESP_OKAY), 32'(s_axi_bresp));
    endtask : wr
    task rd(input logic [ADDR_W-1:0] a);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        while (!s_axi_rvalid) @(posedge aclk);
        s_axi_rready <= 0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : rd
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task ev(input logic viol);
        @(posedge aclk);
        if (viol) viol_req <= 1; else start_op <= 1;
        @(posedge aclk);
        viol_req <= 0; start_op <= 0;
        cyc(12);
    endtask : ev
    // ****************************************
    // scenarios
    // ****************************************
    task t_regs;
        rd(BADDR_INT_CTRL); chk("int_ctrl reset", 32'h00, d);
        rd(BADDR_PRESENCE); chk("presence 1", 32'h82, d);
        rd(BADDR_PRESENCE); chk("presence 2", 32'h86, d);
        rd(BADDR_PRESENCE); chk("presence 3", 32'h82, d);
        rd(18'h3fff0); chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
    endtask : t_regs
    task t_ready_level;
        wr(BADDR_INT_CTRL, 32'h00); ev(0); chk("irq off", 1, irq_n);
        rd(BADDR_INT_CTRL); chk("no pend", 32'h00, d);
        wr(BADDR_INT_CTRL, 32'h01); ev(0); chk("irq ready", 0, irq_n);
        rd(BADDR_INT_CTRL); chk("ready pend", 32'h21, d);
        ev(0); chk("irq still", 0, irq_n);
        wr(BADDR_INT_CTRL, 32'h01); cyc(3); chk("zero write", 0, irq_n);
        wr(BADDR_INT_CTRL, 32'h21); cyc(2); chk("cleared", 1, irq_n);
        rd(BADDR_INT_CTRL); chk("pend gone", 32'h01, d);
        ev(0); chk("irq again", 0, irq_n);
        wr(BADDR_INT_CTRL, 32'h20); cyc(2); chk("irq idle", 1, irq_n);
    endtask : t_ready_level
    task t_viol;
        wr(BADDR_INT_CTRL, 32'h08); ev(1); chk("irq viol", 0, irq_n);
        rd(BADDR_INT_CTRL); chk("viol pend", 32'h48, d);
        wr(BADDR_INT_CTRL, 32'h48); cyc(2); chk("viol clr", 1, irq_n);
        rd(BADDR_INT_CTRL); chk("viol gone", 32'h08, d);
        ev(1); chk("viol again", 0, irq_n);
        wr(BADDR_INT_CTRL, 32'h40); ev(1); chk("viol off", 1, irq_n);
    endtask : t_viol
    task t_edge;
        int n;
        wr(BADDR_INT_CTRL, 32'h11);
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            @(posedge aclk) start_op <= 1;
            @(posedge aclk) start_op <= 0;
            repeat (16)
            begin
                @(posedge aclk);
                if (irq_n === 1'b0) n++;
            end
            // second operation finds the ready flag pending: no pulse
            chk("pulse cycles", (k == 0) ? 32'(PULSE_CYC) : 32'h0, 32'(n));
        end
        rd(BADDR_INT_CTRL); chk("edge pend", 32'h31, d);
        wr(BADDR_INT_CTRL, 32'h20);
    endtask : t_edge
    task t_evt;
        wr(BADDR_EVT_CLEAR, 32'h03); wr(BADDR_EVT_ENABLE, 32'h01);
        wr(BADDR_INT_CTRL, 32'h01); ev(0); chk("evt_irq set", 1, evt_irq);
        wr(BADDR_EVT_ENABLE, 32'h00); cyc(2); chk("evt_irq masked", 0, evt_irq);
        rd(BADDR_EVT_STATUS); chk("evt status", 32'h01, d);
        wr(BADDR_EVT_ENABLE, 32'h01); cyc(2); chk("evt_irq unmask", 1, evt_irq);
        wr(BADDR_EVT_CLEAR, 32'h01); cyc(2); chk("evt_irq clr", 0, evt_irq);
        rd(BADDR_EVT_STATUS); chk("evt status clr", 32'h00, d);
        wr(BADDR_INT_CTRL, 32'h20);
    endtask : t_evt
    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    initial
    begin
        #2000000;
        n_fail++;
        conclude;
    end
    initial
    begin
        cyc(10);
        aresetn <= 1;
        cyc(4);
        t_regs;
        t_ready_level;
        t_viol;
        t_edge;
        t_evt;
        conclude;
    end
endmodule : test_flash_ready_protect_irq

// ===== src/frpi_pkg.sv
package frpi_pkg;

    // ****************************************
    // register map (word offsets)
    // ****************************************
    localparam logic [15:0] ADDR_INT_CTRL    = 16'h100e;
    localparam logic [15:0] ADDR_PRESENCE    = 16'h1046;
    localparam logic [15:0] ADDR_EVT_STATUS  = 16'h1100;
    localparam logic [15:0] ADDR_EVT_ENABLE  = 16'h1104;
    localparam logic [15:0] ADDR_EVT_CLEAR   = 16'h1108;
    localparam logic [15:0] ADDR_PULSE_LEN   = 16'h110c;

    // word-aligned bus addresses: printed offsets are not all multiples of four
    localparam logic [17:0] BADDR_INT_CTRL   = {ADDR_INT_CTRL, 2'b00};
    localparam logic [17:0] BADDR_PRESENCE   = {ADDR_PRESENCE, 2'b00};
    localparam logic [17:0] BADDR_EVT_STATUS = {ADDR_EVT_STATUS, 2'b00};
    localparam logic [17:0] BADDR_EVT_ENABLE = {ADDR_EVT_ENABLE, 2'b00};
    localparam logic [17:0] BADDR_EVT_CLEAR  = {ADDR_EVT_CLEAR, 2'b00};
    localparam logic [17:0] BADDR_PULSE_LEN  = {ADDR_PULSE_LEN, 2'b00};
    localparam int          ADDR_W           = 18;

    // ****************************************
    // interrupt control fields
    // ****************************************
    localparam int          RDY_TRIG_LSB     = 0;
    localparam int          RDY_TRIG_MSB     = 2;
    localparam int          VIOL_EN_BIT      = 3;
    localparam int          EDGE_BIT         = 4;
    localparam int          RDY_PEND_BIT     = 5;
    localparam int          VIOL_PEND_BIT    = 6;
    localparam logic [2:0]  RDY_TRIG_OFF     = 3'h0;
    localparam logic [2:0]  RDY_TRIG_READY   = 3'h1;
    localparam logic [7:0]  INT_CTRL_RESET   = 8'h00;

    // ****************************************
    // presence register
    // ****************************************
    localparam int          TOGGLE_BIT       = 2;
    localparam logic [7:0]  PRESENCE_RESET   = 8'h82;

    // ****************************************
    // event status layout
    // ****************************************
    localparam int          EVT_RDY          = 0;
    localparam int          EVT_VIOL         = 1;
    localparam int          EVT_N            = 2;

    // ****************************************
    // pulse timing: 200 ns low pulse at 20 MHz
    // ****************************************
    localparam int          CLK_PERIOD_NS    = 50;
    localparam int          PULSE_NS         = 200;
    localparam logic [7:0]  PULSE_CYC        = 8'((PULSE_NS + CLK_PERIOD_NS - 1)
                                                   / CLK_PERIOD_NS);

    localparam logic [1:0]  RESP_OKAY        = 2'b00;
    localparam logic [1:0]  RESP_SLVERR      = 2'b10;

endpackage : frpi_pkg

// ===== src/frpi_pulse.sv
`timescale 1ns/1ns
module frpi_pulse
    import frpi_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ce,
    input  wire logic       fire,
    input  wire logic [7:0] len,
    output logic            busy
);
    import frpi_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;
    } frpi_pulse_s;

    frpi_pulse_s st_r;
    frpi_pulse_s st_nxt;

    // counts the pulse cycles that follow the fire cycle
    always_comb
    begin
        st_nxt = st_r;
        if (fire)
            st_nxt.cnt = (len == 8'h00) ? 8'h00 : len - 8'h01;
        else if (st_r.cnt != 8'h00)
            st_nxt.cnt = st_r.cnt - 8'h01;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_r <= '0;
        else if (ce)
            st_r <= st_nxt;
    end

    assign busy = (st_r.cnt != 8'h00);

endmodule : frpi_pulse

// ===== src/frpi_sync.sv
`timescale 1ns/1ns
module frpi_sync
    import frpi_pkg::*;
#(
    parameter int W = 2
)
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    import frpi_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } frpi_sync_s;

    frpi_sync_s st_r;
    frpi_sync_s st_nxt;

    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_r <= '0;
        else if (ce)
            st_r <= st_nxt;
    end

    assign q = st_r.s2;

endmodule : frpi_sync

// ===== src/frpi_top.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ns
// Overview of operation
// - A ready-trigger field of zero blocks ready interrupts; with bit 3 also clear it keeps the irq output negated.
// - A ready-trigger field of one raises an interrupt when the flash goes busy to ready unless the ready pending flag is set.
// - With the violation enable bit 3 set, each protection violation raises an interrupt unless the violation pending flag is set.
// - With edge-select bit 4 clear, irq stays asserted until software clears the pending flag or its trigger/enable field.
// - With edge-select bit 4 set, each interrupt is a low-going pulse on irq.
// - The ready pending flag at bit 5 is set when irq is asserted for flash ready.
// - Writing one to bit 5 clears it and negates irq; writing zero does nothing.
// - The violation pending flag at bit 6 is set when irq is asserted for a violation.
// - Writing one to bit 6 clears it, negates irq and re-enables violation interrupts.
// - Bit 2 of the presence register inverts on every read of that register.
module frpi_top
    import frpi_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  ce,
    // flash and protection status pins
    input  wire logic                  flash_ready,
    input  wire logic                  prot_violation,
    // interrupt outputs
    output logic                       irq_n,
    output logic                       evt_irq,
    // axi4-lite slave
    input  wire logic [frpi_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [frpi_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);
    import frpi_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [2:0]          rdy_trig;
        logic                viol_en;
        logic                edge_mode;
        logic                rdy_pend;
        logic                viol_pend;
        logic                toggle;
        logic [EVT_N-1:0]    evt_stat;
        logic [EVT_N-1:0]    evt_en;
        logic [7:0]          pulse_len;
        logic                rdy_prev;
        logic                viol_prev;
        logic                aw_hold;
        logic [ADDR_W-1:0]   aw_addr;
        logic                w_hold;
        logic [31:0]         w_data;
        logic [3:0]          w_strb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        logic                irq_n;
        logic                evt_irq;
        // registered bus ready flags
        logic                aw_rdy;
        logic                w_rdy;
        logic                ar_rdy;
    } frpi_top_s;

    frpi_top_s st_r;
    frpi_top_s st_nxt;

    logic [1:0] pins_sync;
    logic       pulse_busy;
    logic       fire;

    // ****************************************
    // pin synchroniser and pulse timer
    // ****************************************
    frpi_sync #(
        .W (2)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .d       ({prot_violation, flash_ready}),
        .q       (pins_sync)
    );

    frpi_pulse u_pulse (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .fire    (fire),
        .len     (st_r.pulse_len),
        .busy    (pulse_busy)
    );

    // ****************************************
    // interrupt sources
    // ****************************************
    logic rdy_rise;
    logic viol_rise;
    logic rdy_set;
    logic viol_set;
    logic wr_go;
    logic rd_go;
    logic wr_ctrl;
    logic [7:0] ctrl_rd;

    // synchroniser resets low, so a rise follows reset; harmless, triggers reset off
    assign rdy_rise  = pins_sync[0] && !st_r.rdy_prev;
    assign viol_rise = pins_sync[1] && !st_r.viol_prev;
    assign rdy_set   = rdy_rise && (st_r.rdy_trig == RDY_TRIG_READY)
                       && !st_r.rdy_pend;
    assign viol_set  = viol_rise && st_r.viol_en && !st_r.viol_pend;
    assign fire      = st_r.edge_mode && (rdy_set || viol_set);

    // ****************************************
    // bus decode
    // ****************************************
    assign wr_go   = st_r.aw_hold && st_r.w_hold && !st_r.bvalid;
    assign rd_go   = s_axi_arvalid && !st_r.rvalid;
    assign wr_ctrl = wr_go && (st_r.aw_addr == BADDR_INT_CTRL) && st_r.w_strb[0];

    assign ctrl_rd = {1'b0, st_r.viol_pend, st_r.rdy_pend, st_r.edge_mode,
                      st_r.viol_en, st_r.rdy_trig};

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_nxt           = st_r;
        st_nxt.rdy_prev  = pins_sync[0];
        st_nxt.viol_prev = pins_sync[1];

        // ****************************************
        // write channel capture
        // ****************************************
        if (s_axi_awvalid && !st_r.aw_hold)
        begin
            st_nxt.aw_hold = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_hold)
        begin
            st_nxt.w_hold = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end

        // ****************************************
        // register writes
        // ****************************************
        // pending flag clears, set wins below
        if (wr_ctrl)
        begin
            st_nxt.rdy_trig  = st_r.w_data[RDY_TRIG_MSB:RDY_TRIG_LSB];
            st_nxt.viol_en   = st_r.w_data[VIOL_EN_BIT];
            st_nxt.edge_mode = st_r.w_data[EDGE_BIT];
            if (st_r.w_data[RDY_PEND_BIT])
                st_nxt.rdy_pend = 1'b0;
            if (st_r.w_data[VIOL_PEND_BIT])
                st_nxt.viol_pend = 1'b0;
        end
        if (wr_go && st_r.w_strb[0])
        begin
            if (st_r.aw_addr == BADDR_EVT_ENABLE)
                st_nxt.evt_en = st_r.w_data[EVT_N-1:0];
            if (st_r.aw_addr == BADDR_EVT_CLEAR)
                st_nxt.evt_stat = st_r.evt_stat & ~st_r.w_data[EVT_N-1:0];
            if (st_r.aw_addr == BADDR_PULSE_LEN)
                st_nxt.pulse_len = st_r.w_data[7:0];
        end

        // ****************************************
        // write response
        // ****************************************
        if (wr_go)
        begin
            st_nxt.aw_hold = 1'b0;
            st_nxt.w_hold  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            case (st_r.aw_addr)
                BADDR_INT_CTRL, BADDR_EVT_ENABLE, BADDR_EVT_CLEAR,
                BADDR_PULSE_LEN, BADDR_PRESENCE, BADDR_EVT_STATUS:
                    st_nxt.bresp = RESP_OKAY;
                default:
                    st_nxt.bresp = RESP_SLVERR;
            endcase
        end
        if (st_r.bvalid && s_axi_bready)
            st_nxt.bvalid = 1'b0;

        // ****************************************
        // event capture
        // ****************************************
        if (rdy_set)
        begin
            st_nxt.rdy_pend          = 1'b1;
            st_nxt.evt_stat[EVT_RDY] = 1'b1;
        end
        if (viol_set)
        begin
            st_nxt.viol_pend          = 1'b1;
            st_nxt.evt_stat[EVT_VIOL] = 1'b1;
        end

        // ****************************************
        // read channel
        // ****************************************
        if (rd_go)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = RESP_OKAY;
            st_nxt.rdata  = 32'h0000_0000;
            case (s_axi_araddr)
                BADDR_INT_CTRL:
                    st_nxt.rdata[7:0] = ctrl_rd;
                BADDR_PRESENCE:
                begin
                    st_nxt.rdata[7:0] = PRESENCE_RESET;
                    st_nxt.rdata[TOGGLE_BIT] = st_r.toggle;
                    st_nxt.toggle = !st_r.toggle;
                end
                BADDR_EVT_STATUS:
                    st_nxt.rdata[EVT_N-1:0] = st_r.evt_stat;
                BADDR_EVT_ENABLE:
                    st_nxt.rdata[EVT_N-1:0] = st_r.evt_en;
                BADDR_PULSE_LEN:
                    st_nxt.rdata[7:0] = st_r.pulse_len;
                BADDR_EVT_CLEAR:
                    st_nxt.rdata = 32'h0000_0000;
                default:
                    st_nxt.rresp = RESP_SLVERR;
            endcase
        end
        if (st_r.rvalid && s_axi_rready)
            st_nxt.rvalid = 1'b0;

        // ****************************************
        // interrupt output
        // ****************************************
        // level held while a pending flag and its enable stand; pulse in edge mode
        if (st_nxt.rdy_trig == RDY_TRIG_OFF && !st_nxt.viol_en)
            st_nxt.irq_n = 1'b1;
        else if (st_r.edge_mode)
            st_nxt.irq_n = !(fire || pulse_busy);
        else
            st_nxt.irq_n = !((st_nxt.rdy_pend && st_nxt.rdy_trig == RDY_TRIG_READY)
                             || (st_nxt.viol_pend && st_nxt.viol_en));
        st_nxt.evt_irq = |(st_nxt.evt_stat & st_nxt.evt_en);

        // ****************************************
        // bus ready flags
        // ****************************************
        // awready and wready mirror the free state of their holding flags; arready mirrors a clear rvalid
        st_nxt.aw_rdy  = !st_nxt.aw_hold;
        st_nxt.w_rdy   = !st_nxt.w_hold;
        st_nxt.ar_rdy  = !st_nxt.rvalid;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r           <= '0;
            st_r.toggle    <= PRESENCE_RESET[TOGGLE_BIT];
            st_r.pulse_len <= PULSE_CYC;
            st_r.irq_n     <= 1'b1;
            st_r.aw_rdy    <= 1'b1;
            st_r.w_rdy     <= 1'b1;
            st_r.ar_rdy    <= 1'b1;
        end
        else if (ce)
            st_r <= st_nxt;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign irq_n         = st_r.irq_n;
    assign evt_irq       = st_r.evt_irq;
    assign s_axi_awready = st_r.aw_rdy;
    assign s_axi_wready  = st_r.w_rdy;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.ar_rdy;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;

endmodule : frpi_top
